// ---- src/card_contact_pkg.sv ----
// Constants for the card contact control register block.
// Assumes an 8-bit register port and one card slot.
package card_contact_pkg;
    // Register offsets
    localparam logic [7:0] card_contact_control_addr   = 8'h0a;
    localparam logic [7:0] protocol_mode_register_addr = 8'h0d;
    localparam logic [7:0] contact_config_addr         = 8'h0e;

    // Fields of card_contact_control
    localparam int card_reset_assert_bit   = 7;
    localparam int card_io_bit             = 5;
    localparam int io_direction_select_bit = 4;
    localparam int aux_contact_eight_bit   = 3;
    localparam int aux_contact_four_bit    = 2;
    localparam int clock_hold_level_bit    = 1;
    localparam int clock_halt_bit          = 0;

    // Fields of protocol_mode_register
    localparam int internal_sync_select_bit = 7;

    // Fields of contact_config
    localparam int aux_four_output_bit  = 0;
    localparam int aux_eight_output_bit = 1;
    localparam int bypass_select_bit    = 2;

    // Reset values
    localparam logic [7:0] card_contact_control_reset   = 8'h31;
    localparam logic [7:0] protocol_mode_register_reset = 8'h03;
    localparam logic [7:0] contact_config_reset         = 8'h00;

    // Writable bits of card_contact_control; bit 6 reads zero
    localparam logic [7:0] card_contact_control_mask = 8'hbf;

    // Number of auxiliary contacts
    localparam int aux_count = 2;

    typedef enum logic [1:0] {
        mode_auto,
        mode_bypass,
        mode_sync
    } mode_type;
endpackage : card_contact_pkg

// ---- src/card_contact_control.sv ----
// Card contact control and monitor register with the contact line drivers.
// Assumes the activation sequencer and link clock source sit outside;
// the card clock is derived from link_clk by halving it.
`timescale 1ns/100ps

// Summary of operation
// - Outside sync mode, reset bit 1 drives card reset low; 0 releases it (to the sequencer in auto mode, high in bypass).
// - Reset bit acts in every mode, allowing lengthened or warm reset.
// - Synchronous mode drives reset non-inverted; reset length is ignored.
// - Outside sync mode, reading the I/O bit returns the present I/O line state.
// - Bypass mode drives the written I/O bit onto the I/O line.
// - Synchronous mode I/O bit holds I/O sampled at last clock rise.
// - Aux contact as output drives stored bit; reads return stored bit.
// - Aux contact as input reads back the live pin level.
// - Aux contact as input still stores writes but does not drive.
// - Halt bit 1 holds card clock at the hold level bit.
// - In bypass mode the hold level bit sets the card clock.
// - Internal sync select hands reset and I/O lines to this register; aux lines follow it in every mode.
module card_contact_control (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       link_clk,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       seq_reset_release,
    input  wire logic       seq_io_out,
    input  wire logic       seq_io_oe,
    output logic            card_reset,
    output logic            card_clock,
    input  wire logic       card_io_in,
    output logic            card_io_out,
    output logic            card_io_oe,
    input  wire logic [1:0] aux_contact_in,
    output logic      [1:0] aux_contact_out,
    output logic      [1:0] aux_contact_oe
);

    logic [7:0] card_contact_control;
    logic [7:0] protocol_mode_register;
    logic [7:0] contact_config;
    card_contact_pkg::mode_type mode;

    // Pin synchronisers in the register clock domain
    logic       io_meta;
    logic       io_sync;
    logic [1:0] aux_meta;
    logic [1:0] aux_sync;
    logic       sampled_meta;
    logic       sampled_sync;

    // Link domain
    logic [3:0] ctl_meta;
    logic [3:0] ctl_sync;
    logic       io_meta_link;
    logic       io_sync_link;
    logic       io_sampled;
    logic       next_card_clock;

    logic [7:0] read_value;
    logic       sel_control;

    assign sel_control = (addr == card_contact_pkg::card_contact_control_addr);

    // Sync mode wins over bypass when both are selected
    always_comb
    begin
        if (protocol_mode_register[card_contact_pkg::internal_sync_select_bit])
            mode = card_contact_pkg::mode_sync;
        else if (contact_config[card_contact_pkg::bypass_select_bit])
            mode = card_contact_pkg::mode_bypass;
        else
            mode = card_contact_pkg::mode_auto;
    end

    // Register writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            card_contact_control <= card_contact_pkg::card_contact_control_reset;
        else if (wr && sel_control)
            card_contact_control <= wdata & card_contact_pkg::card_contact_control_mask;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            protocol_mode_register <= card_contact_pkg::protocol_mode_register_reset;
        else if (wr && addr == card_contact_pkg::protocol_mode_register_addr)
            protocol_mode_register <= wdata;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            contact_config <= card_contact_pkg::contact_config_reset;
        else if (wr && addr == card_contact_pkg::contact_config_addr)
            contact_config <= {5'h00, wdata[2:0]};
    end

    // Two flops on every pin read; costs two cycles of latency on reads
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            io_meta      <= 1'b0;
            io_sync      <= 1'b0;
            aux_meta     <= 2'h0;
            aux_sync     <= 2'h0;
            sampled_meta <= 1'b0;
            sampled_sync <= 1'b0;
        end
        else
        begin
            io_meta      <= card_io_in;
            io_sync      <= io_meta;
            aux_meta     <= aux_contact_in;
            aux_sync     <= aux_meta;
            sampled_meta <= io_sampled;
            sampled_sync <= sampled_meta;
        end
    end

    // Read mux: pin levels always replace the I/O bit, and replace aux bits where they are inputs
    always_comb
    begin
        read_value = card_contact_control;
        if (mode == card_contact_pkg::mode_sync)
            read_value[card_contact_pkg::card_io_bit] = sampled_sync;
        else
            read_value[card_contact_pkg::card_io_bit] = io_sync;
        if (!contact_config[card_contact_pkg::aux_four_output_bit])
            read_value[card_contact_pkg::aux_contact_four_bit] = aux_sync[0];
        if (!contact_config[card_contact_pkg::aux_eight_output_bit])
            read_value[card_contact_pkg::aux_contact_eight_bit] = aux_sync[1];
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (!rd)
            rdata <= 8'h00;
        else if (sel_control)
            rdata <= read_value;
        else if (addr == card_contact_pkg::protocol_mode_register_addr)
            rdata <= protocol_mode_register;
        else if (addr == card_contact_pkg::contact_config_addr)
            rdata <= contact_config;
        else
            rdata <= 8'h00;
    end

    // Card reset: register bit overrides the sequencer in every mode
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            card_reset <= 1'b0;
        else
        begin
            unique case (mode)
                card_contact_pkg::mode_sync:
                    card_reset <= card_contact_control[card_contact_pkg::card_reset_assert_bit];
                card_contact_pkg::mode_bypass:
                    card_reset <= !card_contact_control[card_contact_pkg::card_reset_assert_bit];
                card_contact_pkg::mode_auto:
                    // Bit at 0 leaves the release to the sequencer
                    card_reset <= !card_contact_control[card_contact_pkg::card_reset_assert_bit]
                                  && seq_reset_release;
            endcase
        end
    end

    // Card I/O driver
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            card_io_out <= 1'b0;
            card_io_oe  <= 1'b0;
        end
        else if (mode == card_contact_pkg::mode_auto)
        begin
            card_io_out <= seq_io_out;
            card_io_oe  <= seq_io_oe;
        end
        else
        begin
            card_io_out <= card_contact_control[card_contact_pkg::card_io_bit];
            card_io_oe  <= !card_contact_control[card_contact_pkg::io_direction_select_bit];
        end
    end

    // Auxiliary contacts: stored bit is driven only while configured as output
    genvar i;
    generate
        for (i = 0; i < card_contact_pkg::aux_count; i++)
        begin : aux_drive
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    aux_contact_out[i] <= 1'b0;
                    aux_contact_oe[i]  <= 1'b0;
                end
                else
                begin
                    aux_contact_out[i] <=
                        card_contact_control[card_contact_pkg::aux_contact_four_bit + i];
                    aux_contact_oe[i]  <= contact_config[i];
                end
            end
        end
    endgenerate

    // Control bits into the link domain as levels
    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // Match the register's reset (halted low) so no clock burst follows reset
            ctl_meta <= 4'h1;
            ctl_sync <= 4'h1;
        end
        else
        begin
            ctl_meta <= {mode == card_contact_pkg::mode_sync,
                         mode == card_contact_pkg::mode_bypass,
                         card_contact_control[card_contact_pkg::clock_hold_level_bit],
                         card_contact_control[card_contact_pkg::clock_halt_bit]};
            ctl_sync <= ctl_meta;
        end
    end

    // Card clock is link_clk halved; bypass and halt hold the chosen level
    always_comb
    begin
        if (ctl_sync[2])
            next_card_clock = ctl_sync[1];
        else if (ctl_sync[0])
            next_card_clock = ctl_sync[1];
        else
            next_card_clock = !card_clock;
    end

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
            card_clock <= 1'b0;
        else
            card_clock <= next_card_clock;
    end

    // I/O sampled at each rising card clock edge while in sync mode
    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            io_meta_link <= 1'b0;
            io_sync_link <= 1'b0;
            io_sampled   <= 1'b0;
        end
        else
        begin
            io_meta_link <= card_io_in;
            io_sync_link <= io_meta_link;
            if (ctl_sync[3] && next_card_clock && !card_clock)
                io_sampled <= io_sync_link;
        end
    end

endmodule : card_contact_control

// ---- test/card_contact_monitor.sv ----
// Checker on the ports of the card contact register block.
// Assumes it is bound to card_contact_control.
`timescale 1ns/100ps
module card_contact_monitor (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       link_clk,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       seq_reset_release,
    input wire logic       card_reset,
    input wire logic       card_clock,
    input wire logic       card_io_out,
    input wire logic       card_io_oe,
    input wire logic [1:0] aux_contact_out,
    input wire logic [1:0] aux_contact_oe
);
    logic [7:0] ctl;
    logic [2:0] cfg;
    logic       syn;
    logic       byp;
    logic       held;
    assign byp  = cfg[2] && !syn;
    assign held = (byp || ctl[0]) && !syn;
    // Shadow of the stored bits, updated on the same edge as the block
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctl <= 8'h31;
            cfg <= 3'h0;
            syn <= 1'b0;
        end
        else if (wr)
        begin
            if (addr == 8'h0a)
                ctl <= wdata;
            if (addr == 8'h0d)
                syn <= wdata[7];
            if (addr == 8'h0e)
                cfg <= wdata[2:0];
        end
    end
    // Five link edges: two sync flops, the clock flop and margin for skew
    sequence s_hold_hi;
        (held && ctl[1])[*5];
    endsequence
    sequence s_hold_lo;
        (held && !ctl[1])[*5];
    endsequence
    sequence s_run;
        (!held && !syn)[*5];
    endsequence
    property p_rd_idle;
        @(posedge clk) disable iff (!nrst) !rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rst_auto;
        @(posedge clk) disable iff (!nrst) !byp && !syn
            |=> card_reset == (!$past(ctl[7]) && $past(seq_reset_release));
    endproperty
    a_rst_auto: assert property (p_rst_auto) else $error("auto reset wrong");
    property p_rst_byp;
        @(posedge clk) disable iff (!nrst) byp |=> card_reset == !$past(ctl[7]);
    endproperty
    a_rst_byp: assert property (p_rst_byp) else $error("bypass reset wrong");
    property p_rst_sync;
        @(posedge clk) disable iff (!nrst) syn |=> card_reset == $past(ctl[7]);
    endproperty
    a_rst_sync: assert property (p_rst_sync) else $error("sync reset wrong");
    property p_io;
        @(posedge clk) disable iff (!nrst) byp || syn |=> card_io_oe == !$past(ctl[4])
            && (!card_io_oe || card_io_out == $past(ctl[5]));
    endproperty
    a_io: assert property (p_io) else $error("io drive wrong");
    property p_aux;
        @(posedge clk) disable iff (!nrst) 1'b1 |=> aux_contact_oe == $past(cfg[1:0])
            && ((aux_contact_out ^ $past(ctl[3:2])) & aux_contact_oe) == 2'h0;
    endproperty
    a_aux: assert property (p_aux) else $error("aux drive wrong");
    property p_clk_hi;
        @(posedge link_clk) disable iff (!nrst) s_hold_hi |-> card_clock;
    endproperty
    a_clk_hi: assert property (p_clk_hi) else $error("clock not high");
    property p_clk_lo;
        @(posedge link_clk) disable iff (!nrst) s_hold_lo |-> !card_clock;
    endproperty
    a_clk_lo: assert property (p_clk_lo) else $error("clock not low");
    property p_clk_run;
        @(posedge link_clk) disable iff (!nrst) s_run |-> card_clock != $past(card_clock);
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock not running");
endmodule : card_contact_monitor
bind card_contact_control card_contact_monitor mon (.clk, .nrst, .link_clk, .addr, .wdata,
    .wr, .rd, .rdata, .seq_reset_release, .card_reset, .card_clock, .card_io_out,
    .card_io_oe, .aux_contact_out, .aux_contact_oe);

// ---- test/smart_card_model.sv ----
// Card on the contact lines, driving I/O and aux lines when told to.
// Assumes pull-ups on every line, so a released line reads high.
`timescale 1ns/100ps
module smart_card_model (
    input  wire logic       card_clock,
    input  wire logic       card_io_out,
    input  wire logic       card_io_oe,
    input  wire logic [1:0] aux_contact_out,
    input  wire logic [1:0] aux_contact_oe,
    input  wire logic [2:0] drive_en,
    input  wire logic [2:0] drive_val,
    output logic            card_io_in,
    output logic      [1:0] aux_contact_in,
    output logic      [7:0] clock_rises
);
    assign card_io_in        = card_io_oe ? card_io_out : !drive_en[2] || drive_val[2];
    assign aux_contact_in[0] = aux_contact_oe[0] ? aux_contact_out[0]
                                                 : !drive_en[0] || drive_val[0];
    assign aux_contact_in[1] = aux_contact_oe[1] ? aux_contact_out[1]
                                                 : !drive_en[1] || drive_val[1];
    initial
        clock_rises = 8'h00;
    always @(posedge card_clock)
        clock_rises <= clock_rises + 8'h01;
endmodule : smart_card_model

// ---- test/test_smart_card_pin_control.sv ----
// Bench for the card contact register block and its contact lines.
// Assumes the card model answers on I/O and aux lines.
`timescale 1ns/100ps
module test_smart_card_pin_control;
    localparam logic [7:0] ctl_a = card_contact_pkg::card_contact_control_addr;
    localparam logic [7:0] mod_a = card_contact_pkg::protocol_mode_register_addr;
    localparam logic [7:0] cfg_a = card_contact_pkg::contact_config_addr;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       link_clk = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       seq_reset_release = 1'b0;
    logic [2:0] drv_en = 3'h3;
    logic [2:0] drv_val = 3'h0;
    logic [7:0] rdata, rises, mark;
    logic       card_reset, card_clock, card_io_in, card_io_out, card_io_oe;
    logic [1:0] aux_contact_in, aux_contact_out, aux_contact_oe;
    int         bad_count = 0;
    int         comparisons = 0;
    card_contact_control DUT (.clk, .nrst, .link_clk, .addr, .wdata, .wr, .rd, .rdata,
        .seq_reset_release, .seq_io_out(1'b0), .seq_io_oe(1'b0), .card_reset, .card_clock,
        .card_io_in, .card_io_out, .card_io_oe, .aux_contact_in, .aux_contact_out,
        .aux_contact_oe);
    smart_card_model card (.card_clock, .card_io_out, .card_io_oe, .aux_contact_out,
        .aux_contact_oe, .drive_en(drv_en), .drive_val(drv_val), .card_io_in,
        .aux_contact_in, .clock_rises(rises));
    initial
        forever #12.5 clk = ~clk;
    // Odd offset keeps the link edges off the register clock
    initial
    begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, rdata, exp);
        @(posedge clk);
    endtask : rd_reg
    // Long enough for the two link flops and the pin read flops
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    initial
    begin
        #100000;
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Pin read flops need two edges before the first read is taken
        repeat (3) @(posedge clk);
        rd_reg("ctl", ctl_a, 8'h31);
        rd_reg("mode", mod_a, 8'h03);
        rd_reg("cfg", cfg_a, 8'h00);
        rd_reg("unmapped", 8'h20, 8'h00);
        settle(16);
        check("rst", {7'h0, card_reset}, 8'h00);
        check("clk", {7'h0, card_clock}, 8'h00);
        seq_reset_release <= 1'b1;
        settle(4);
        check("rst", {7'h0, card_reset}, 8'h01);
        wr_reg(ctl_a, 8'hb1);
        settle(2);
        check("rst", {7'h0, card_reset}, 8'h00);
        wr_reg(ctl_a, 8'h31);
        drv_en  <= 3'h7;
        drv_val <= 3'h2;
        settle(4);
        check("rst", {7'h0, card_reset}, 8'h01);
        rd_reg("ctl", ctl_a, 8'h19);
        wr_reg(ctl_a, 8'h3d);
        settle(4);
        check("aux oe", {6'h0, aux_contact_oe}, 8'h00);
        rd_reg("ctl", ctl_a, 8'h19);
        drv_en <= 3'h4;
        wr_reg(cfg_a, 8'h03);
        settle(4);
        check("aux", {4'h0, aux_contact_oe, aux_contact_out}, 8'h0f);
        rd_reg("ctl", ctl_a, 8'h1d);
        drv_en <= 3'h0;
        wr_reg(cfg_a, 8'h07);
        wr_reg(ctl_a, 8'h2e);
        settle(16);
        mark <= rises;
        check("byp", {5'h0, card_reset, card_io_oe, card_io_out}, 8'h07);
        settle(16);
        check("clk", {7'h0, card_clock}, 8'h01);
        check("rises", rises, mark);
        wr_reg(ctl_a, 8'h8c);
        settle(16);
        check("byp", {5'h0, card_reset, card_io_oe, card_io_out}, 8'h02);
        check("clk", {7'h0, card_clock}, 8'h00);
        rd_reg("ctl", ctl_a, 8'h8c);
        wr_reg(mod_a, 8'h83);
        wr_reg(ctl_a, 8'h90);
        drv_en  <= 3'h4;
        drv_val <= 3'h4;
        settle(16);
        check("sync", {6'h0, card_reset, card_io_oe}, 8'h02);
        rd_reg("ctl", ctl_a, 8'hb0);
        drv_val <= 3'h0;
        settle(16);
        rd_reg("ctl", ctl_a, 8'h90);
        wr_reg(ctl_a, 8'h10);
        settle(2);
        check("rst", {7'h0, card_reset}, 8'h00);
        wr_reg(mod_a, 8'h03);
        wr_reg(cfg_a, 8'h00);
        wr_reg(ctl_a, 8'h30);
        settle(16);
        mark <= rises;
        settle(40);
        check("run", {7'h0, rises - mark >= 8'h06}, 8'h01);
        wr_reg(ctl_a, 8'h33);
        settle(16);
        mark <= rises;
        settle(16);
        check("clk", {7'h0, card_clock}, 8'h01);
        check("rises", rises, mark);
        close_out();
    end
endmodule : test_smart_card_pin_control
